// ### config_word_decoder.sv
// Function
// - Hold 12-bit nonvolatile configuration word
// - Only configuration bit disables watchdog
// - Bit 3 set enables watchdog
// - Watchdog ticks from own RC oscillator
// - Crystal modes always get 18 ms delay
// - RC modes: 1 ms, power-up only
// - Codes 000-010 crystal modes, 18 ms
// - Code 011 external clock, pin GPIO
// - Codes 100/101 internal RC, GPIO/clock out
// - Codes 110/111 external RC, GPIO/clock out
// - Bit 6 selects 8 or 4 MHz
// - Bit 5 enables reset pin, else tied
// - Bit 4 clear protects program memory
// - Bit 7 clear protects data flash
// - Sleep wakes on pin change or watchdog
`timescale 1ns/10ps
`default_nettype none
`include "config_word_map.svh"

module config_word_decoder
   import config_word_pkg::*;
#(
   parameter int WAKE_PINS = 6,
   parameter int WDT_CW = 16,
   parameter int WDT_TICKS = `WDT_TICKS_DEF,
   parameter int DRT_LONG_CYC = `DRT_LONG_US * (`PCLK_KHZ / 1000),
   parameter int DRT_SHORT_CYC = `DRT_SHORT_US * (`PCLK_KHZ / 1000)
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Nonvolatile configuration cells
   input wire logic [`CFG_W-1:0] nv_config_word,
   // Pins and core events
   input wire logic reset_pin_in,
   input wire logic [WAKE_PINS-1:0] wake_pin_in,
   input wire logic wdt_osc_in,
   input wire logic wdt_clear,
   // Core reset and power state
   output logic core_reset_n,
   output logic sleep_active,
   output logic wdt_timeout,
   // Decoded settings
   output osc_mode_t osc_mode,
   output logic clkout_enable,
   output logic osc2_is_port_b_bit_four,
   output logic int_osc_8mhz,
   output logic reset_pin_is_gpio,
   output logic watchdog_enabled,
   output logic program_protect_on,
   output logic data_flash_protect_on
);

   localparam int SYNC_W = WAKE_PINS + 2;
   localparam int RST_IDX = WAKE_PINS;
   localparam int OSC_IDX = WAKE_PINS + 1;

   // ==========================================================
   // Parameter check
   if (WAKE_PINS < 1 || WAKE_PINS > 24 || WDT_TICKS < 2
       || WDT_TICKS >= (1 << WDT_CW))
   begin : g_bad
      $error("config_word_decoder: unsupported parameter values");
   end

   // ==========================================================
   // Functions

   // Crystal modes need their oscillator settled on every reset
   function automatic logic is_crystal(input osc_mode_t m);
      return (m == low_power_crystal_mode) ||
             (m == standard_crystal_mode) ||
             (m == high_speed_crystal_mode);
   endfunction

   // Delay length for the mode and the kind of reset
   function automatic drt_len_t drt_for(input osc_mode_t m,
                                        input logic por);
      if (is_crystal(m))
         return drt_long;
      else if (por)
         return drt_short;
      else
         return drt_none;
   endfunction

   // ==========================================================
   // Declarations
   logic [`CFG_W-1:0] nv_s1_reg;
   logic [`CFG_W-1:0] nv_s2_reg;
   logic [`CFG_W-1:0] nv_s3_reg;
   logic [1:0] settle_reg;
   logic [`CFG_W-1:0] cfg_reg;
   logic [SYNC_W-1:0] pin_s1_reg;
   logic [SYNC_W-1:0] pin_s2_reg;
   logic [SYNC_W-1:0] pin_s3_reg;
   logic [SYNC_W-1:0] filt_reg;
   logic [SYNC_W-1:0] filt_prev_reg;
   seq_state_t state_reg;
   seq_state_t state_next;
   reset_cause_t cause_reg;
   reset_cause_t cause_next;
   logic [WDT_CW-1:0] wdt_cnt_reg;
   logic wdt_flag_reg;
   logic [WAKE_PINS-1:0] wake_mask_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic core_reset_n_reg;
   logic sleep_reg;
   osc_mode_t osc_mode_reg;
   logic clkout_reg;
   logic gpio_osc2_reg;
   logic speed_reg;
   logic rst_gpio_reg;
   logic wdt_en_reg;
   logic prog_prot_reg;
   logic data_prot_reg;

   // ==========================================================
   // Configuration word capture
   // Cells are outside this clock domain, so three stages; the
   // word is taken only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nv_s1_reg <= '0;
         nv_s2_reg <= '0;
         nv_s3_reg <= '0;
         settle_reg <= '0;
      end
      else
      begin
         nv_s1_reg <= nv_config_word;
         nv_s2_reg <= nv_s1_reg;
         nv_s3_reg <= nv_s2_reg;
         if (settle_reg != `SETTLE_CYC)
            settle_reg <= settle_reg + 2'h1;
      end
   end

   // Word is frozen after load; it only changes across power-up
   wire cfg_stable = (settle_reg == `SETTLE_CYC) &&
                     (nv_s2_reg == nv_s3_reg);
   wire cfg_load = (state_reg == st_load) && cfg_stable;

   // Erased state until loaded, which is the unprotected setting
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= '1;
      else if (cfg_load)
         cfg_reg <= nv_s3_reg;
   end

   // ==========================================================
   // Field decode
   wire osc_mode_t osc_sel = osc_mode_t'(cfg_reg[`CFG_OSC_MSB:`CFG_OSC_LSB]);
   wire osc_mode_t load_sel =
      osc_mode_t'(nv_s3_reg[`CFG_OSC_MSB:`CFG_OSC_LSB]);
   wire dec_wdt_en = cfg_reg[`CFG_WDT_BIT];
   wire dec_mrst_en = cfg_reg[`CFG_MRST_BIT];
   // Codes 011,100,110 free the pin; 101,111 drive clock out
   wire dec_clkout = (osc_sel == internal_rc_clkout_mode) ||
                     (osc_sel == external_rc_clkout_mode);
   wire dec_gpio_osc2 = (osc_sel == external_clock_mode) ||
                        (osc_sel == internal_rc_mode) ||
                        (osc_sel == external_rc_mode);

   // ==========================================================
   // Pin synchronisers: wake pins, reset pin, watchdog oscillator
   // A level moves only when stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_reg <= '1;
         pin_s2_reg <= '1;
         pin_s3_reg <= '1;
         filt_reg <= '1;
         filt_prev_reg <= '1;
      end
      else
      begin
         pin_s1_reg <= {wdt_osc_in, reset_pin_in, wake_pin_in};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         filt_reg <= (pin_s2_reg & pin_s3_reg) |
                     (filt_reg & (pin_s2_reg | pin_s3_reg));
         filt_prev_reg <= filt_reg;
      end
   end

   // When disabled, the internal reset is held inactive high
   wire mrst_active = dec_mrst_en && !filt_reg[RST_IDX];
   wire [WAKE_PINS-1:0] pin_change =
      (filt_reg[WAKE_PINS-1:0] ^ filt_prev_reg[WAKE_PINS-1:0]) &
      wake_mask_reg;
   // Watchdog time base is its own RC oscillator, not pclk
   wire wdt_tick = filt_reg[OSC_IDX] && !filt_prev_reg[OSC_IDX];

   // ==========================================================
   // Watchdog counter
   // There is no software disable: only the config bit stops it
   wire wdt_live = dec_wdt_en &&
                   ((state_reg == st_run) || (state_reg == st_sleep));
   wire wdt_fire = wdt_live && wdt_tick &&
                   (wdt_cnt_reg == WDT_CW'(WDT_TICKS - 1));

   // ==========================================================
   // APB decode
   wire apb_access = psel && penable && !pready_reg;
   wire apb_commit = psel && penable && pready_reg;
   wire apb_wr = apb_commit && pwrite;
   wire hit_config = (paddr == `REG_CONFIG);
   wire hit_status = (paddr == `REG_STATUS);
   wire hit_ctrl = (paddr == `REG_CTRL);
   wire hit_mask = (paddr == `REG_WAKE_MASK);
   wire hit_wdt = (paddr == `REG_WDT_COUNT);
   wire addr_hit = hit_config || hit_status || hit_ctrl ||
                   hit_mask || hit_wdt;
   wire ctrl_wr = apb_wr && hit_ctrl;
   wire sleep_req = ctrl_wr && pwdata[`CTRL_SLEEP_BIT];
   wire wdt_sw_clr = ctrl_wr && pwdata[`CTRL_WDT_CLR_BIT];
   wire flag_clr = ctrl_wr && pwdata[`CTRL_FLAG_CLR_BIT];

   // Watchdog restarts on clear, on time-out and outside run/sleep
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdt_cnt_reg <= '0;
      else if (!wdt_live || wdt_clear || wdt_sw_clr || wdt_fire)
         wdt_cnt_reg <= '0;
      else if (wdt_tick)
         wdt_cnt_reg <= wdt_cnt_reg + WDT_CW'(1);
   end

   // Sticky time-out flag; a new time-out wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdt_flag_reg <= 1'b0;
      else if (wdt_fire)
         wdt_flag_reg <= 1'b1;
      else if (flag_clr)
         wdt_flag_reg <= 1'b0;
   end

   // ==========================================================
   // Start-up delay timer
   wire drt_busy;
   logic drt_start;
   drt_len_t drt_len;

   startup_delay_timer #(
      .CNT_W(20),
      .LONG_CYC(DRT_LONG_CYC),
      .SHORT_CYC(DRT_SHORT_CYC)
   ) u_drt (
      .pclk(pclk),
      .presetn(presetn),
      .start(drt_start),
      .len(drt_len),
      .busy(drt_busy)
   );

   // ==========================================================
   // Reset and sleep sequencer
   // Every reset other than power-up uses the non-POR length, so
   // RC modes restart at once while crystal modes wait again
   always_comb
   begin
      state_next = state_reg;
      cause_next = cause_reg;
      drt_start = 1'b0;
      drt_len = drt_for(osc_sel, 1'b0);
      case (state_reg)
         st_load:
         begin
            if (cfg_stable)
            begin
               drt_start = 1'b1;
               drt_len = drt_for(load_sel, 1'b1);
               state_next = st_delay;
            end
         end
         st_delay:
         begin
            // Pin held low keeps reloading the delay
            if (mrst_active)
            begin
               drt_start = 1'b1;
               cause_next = cause_pin;
            end
            else if (!drt_busy)
               state_next = st_run;
         end
         st_run:
         begin
            if (mrst_active || wdt_fire)
            begin
               drt_start = 1'b1;
               cause_next = mrst_active ? cause_pin : cause_wdt;
               state_next = st_delay;
            end
            else if (sleep_req)
               state_next = st_sleep;
         end
         st_sleep:
         begin
            if (mrst_active || wdt_fire || (pin_change != '0))
            begin
               drt_start = 1'b1;
               cause_next = mrst_active ? cause_pin :
                            (wdt_fire ? cause_wdt : cause_wake);
               state_next = st_delay;
            end
         end
         default:
            state_next = st_load;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= st_load;
         cause_reg <= cause_por;
      end
      else
      begin
         state_reg <= state_next;
         cause_reg <= cause_next;
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_mask_reg <= '0;
      else if (apb_wr && hit_mask)
         wake_mask_reg <= pwdata[WAKE_PINS-1:0];
   end

   // Read mux; reserved bits read as zero
   wire [31:0] status_word = 32'({cause_reg, wdt_flag_reg, drt_busy,
                                  sleep_reg, !core_reset_n_reg});
   wire [31:0] rd_mux = hit_config ? 32'(cfg_reg) :
                        hit_status ? status_word :
                        hit_mask ? 32'(wake_mask_reg) :
                        hit_wdt ? 32'(wdt_cnt_reg) :
                        32'h0000_0000;

   // One wait state: pready is a flop, so reads come registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= apb_access;
         pslverr_reg <= apb_access && !addr_hit;
         if (apb_access)
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_reset_n_reg <= 1'b0;
         sleep_reg <= 1'b0;
         osc_mode_reg <= external_rc_clkout_mode;
         clkout_reg <= 1'b0;
         gpio_osc2_reg <= 1'b0;
         speed_reg <= 1'b1;
         rst_gpio_reg <= 1'b0;
         wdt_en_reg <= 1'b1;
         prog_prot_reg <= 1'b0;
         data_prot_reg <= 1'b0;
      end
      else
      begin
         core_reset_n_reg <= (state_next == st_run);
         sleep_reg <= (state_next == st_sleep);
         osc_mode_reg <= osc_sel;
         clkout_reg <= dec_clkout;
         gpio_osc2_reg <= dec_gpio_osc2;
         speed_reg <= cfg_reg[`CFG_SPEED_BIT];
         rst_gpio_reg <= !dec_mrst_en;
         wdt_en_reg <= dec_wdt_en;
         prog_prot_reg <= !cfg_reg[`CFG_PROG_BIT];
         data_prot_reg <= !cfg_reg[`CFG_DATA_BIT];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign core_reset_n = core_reset_n_reg;
   assign sleep_active = sleep_reg;
   assign wdt_timeout = wdt_flag_reg;
   assign osc_mode = osc_mode_reg;
   assign clkout_enable = clkout_reg;
   assign osc2_is_port_b_bit_four = gpio_osc2_reg;
   assign int_osc_8mhz = speed_reg;
   assign reset_pin_is_gpio = rst_gpio_reg;
   assign watchdog_enabled = wdt_en_reg;
   assign program_protect_on = prog_prot_reg;
   assign data_flash_protect_on = data_prot_reg;

endmodule
`default_nettype wire

// ### config_word_map.svh
`ifndef CONFIG_WORD_MAP_SVH
`define CONFIG_WORD_MAP_SVH

// ==========================================================
// Configuration word layout
`define CFG_W 12
`define CFG_OSC_LSB 0
`define CFG_OSC_MSB 2
`define CFG_WDT_BIT 3
`define CFG_PROG_BIT 4
`define CFG_MRST_BIT 5
`define CFG_SPEED_BIT 6
`define CFG_DATA_BIT 7

// ==========================================================
// Oscillator select codes
`define OSC_LP 3'h0
`define OSC_XT 3'h1
`define OSC_HS 3'h2
`define OSC_EC 3'h3
`define OSC_INTERNAL_RC_MODE_IO 3'h4
`define OSC_INTERNAL_RC_MODE_CLK 3'h5
`define OSC_EXTERNAL_RC_MODE_IO 3'h6
`define OSC_EXTERNAL_RC_MODE_CLK 3'h7

// ==========================================================
// APB register byte offsets
`define REG_CONFIG 12'h000
`define REG_STATUS 12'h004
`define REG_CTRL 12'h008
`define REG_WAKE_MASK 12'h00C
`define REG_WDT_COUNT 12'h010

// Control register bits (write only, self clearing)
`define CTRL_SLEEP_BIT 0
`define CTRL_WDT_CLR_BIT 1
`define CTRL_FLAG_CLR_BIT 2

// Status register bits
`define ST_IN_RESET_BIT 0
`define ST_SLEEP_BIT 1
`define ST_DRT_BUSY_BIT 2
`define ST_WDT_FLAG_BIT 3
`define ST_CAUSE_LSB 4
`define ST_CAUSE_MSB 5

// ==========================================================
// Timing
`define PCLK_KHZ 40000
`define DRT_LONG_US 18000
`define DRT_SHORT_US 1000
`define WDT_TICKS_DEF 576
`define SETTLE_CYC 2'h3

`endif

// ### config_word_pkg.sv
`default_nettype none
`include "config_word_map.svh"

package config_word_pkg;

   // Oscillator modes, encoded as the select field
   typedef enum logic [2:0] {
      low_power_crystal_mode = `OSC_LP,
      standard_crystal_mode = `OSC_XT,
      high_speed_crystal_mode = `OSC_HS,
      external_clock_mode = `OSC_EC,
      internal_rc_mode = `OSC_INTERNAL_RC_MODE_IO,
      internal_rc_clkout_mode = `OSC_INTERNAL_RC_MODE_CLK,
      external_rc_mode = `OSC_EXTERNAL_RC_MODE_IO,
      external_rc_clkout_mode = `OSC_EXTERNAL_RC_MODE_CLK
   } osc_mode_t;

   // Start-up delay lengths
   typedef enum logic [1:0] {
      drt_none = 2'h0,
      drt_short = 2'h1,
      drt_long = 2'h2
   } drt_len_t;

   // Sequencer states, Gray along load-delay-run-sleep
   typedef enum logic [1:0] {
      st_load = 2'h0,
      st_delay = 2'h1,
      st_run = 2'h3,
      st_sleep = 2'h2
   } seq_state_t;

   // Cause of the most recent reset
   typedef enum logic [1:0] {
      cause_por = 2'h0,
      cause_pin = 2'h1,
      cause_wdt = 2'h2,
      cause_wake = 2'h3
   } reset_cause_t;

endpackage
`default_nettype wire

// ### startup_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "config_word_map.svh"

module startup_delay_timer
   import config_word_pkg::*;
#(
   parameter int CNT_W = 20,
   parameter int LONG_CYC = 720000,
   parameter int SHORT_CYC = 40000
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   input wire drt_len_t len,
   // Status
   output logic busy
);

   logic [CNT_W-1:0] cnt_reg;
   logic busy_reg;
   logic [CNT_W-1:0] load_val;

   // ==========================================================
   // Parameter check
   if (LONG_CYC < 1 || SHORT_CYC < 1 || LONG_CYC >= (1 << CNT_W)
       || SHORT_CYC >= (1 << CNT_W))
   begin : g_bad
      $error("startup_delay_timer: count does not fit counter");
   end

   // Load value; a count of N keeps busy high for N cycles
   assign load_val = (len == drt_long) ? CNT_W'(LONG_CYC - 1) :
                     CNT_W'(SHORT_CYC - 1);

   // ==========================================================
   // Down counter; a restart reloads, so a held start holds busy unless len is drt_none
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
      end
      else if (start)
      begin
         cnt_reg <= load_val;
         busy_reg <= (len != drt_none);
      end
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - CNT_W'(1);
      else
         busy_reg <= 1'b0;
   end

   assign busy = busy_reg;

endmodule
`default_nettype wire

// ### config_word_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the configuration word decoder
module config_word_asserts
   import config_word_pkg::*;
#(
   parameter int DRT_LONG_CYC = 40
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Word and pins
   input wire logic [11:0] nv_config_word,
   input wire logic reset_pin_in,
   // Core state
   input wire logic core_reset_n,
   input wire logic wdt_timeout,
   // Decoded settings
   input wire osc_mode_t osc_mode,
   input wire logic clkout_enable,
   input wire logic osc2_is_port_b_bit_four,
   input wire logic int_osc_8mhz,
   input wire logic reset_pin_is_gpio,
   input wire logic watchdog_enabled,
   input wire logic program_protect_on,
   input wire logic data_flash_protect_on
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Word is stable while the core runs, so outputs must match it
   wire logic [2:0] code;
   assign code = nv_config_word[2:0];
   int low_cnt;

   // Length of the current core reset, for the delay check
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         low_cnt <= 0;
      else if (core_reset_n)
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;

   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_pulse;
      pready ##1 !pready;
   endsequence

   a_apb_one_wait: assert property (s_access |=> s_pulse)
      else $error("bus answer not a single cycle");
   a_osc_mode_map: assert property (core_reset_n |-> osc_mode == code)
      else $error("mode differs from word");
   a_clkout_codes: assert property (core_reset_n |->
      clkout_enable == (code == 3'h5 || code == 3'h7))
      else $error("clock out wrong");
   a_port_pin_codes: assert property (core_reset_n |->
      osc2_is_port_b_bit_four == (code inside {3'h3, 3'h4, 3'h6}))
      else $error("port pin function wrong");
   a_speed_bit: assert property (core_reset_n |->
      int_osc_8mhz == nv_config_word[6])
      else $error("speed select wrong");
   a_wdt_enable_bit: assert property (core_reset_n |->
      watchdog_enabled == nv_config_word[3])
      else $error("watchdog enable wrong");
   a_reset_pin_gpio: assert property (core_reset_n |->
      reset_pin_is_gpio == !nv_config_word[5])
      else $error("reset pin function wrong");
   a_protect_bits: assert property (core_reset_n |->
      {program_protect_on, data_flash_protect_on} ==
      {!nv_config_word[4], !nv_config_word[7]})
      else $error("protection wrong");
   a_pin_reset_held: assert property (
      (!reset_pin_is_gpio && !reset_pin_in)[*8] |-> !core_reset_n)
      else $error("pin low but core runs");
   a_wdt_off_quiet: assert property (
      core_reset_n && !watchdog_enabled |-> !$rose(wdt_timeout))
      else $error("disabled watchdog fired");
   a_drt_long_hold: assert property ($rose(core_reset_n) &&
      osc_mode inside {3'h0, 3'h1, 3'h2} |-> low_cnt >= DRT_LONG_CYC)
      else $error("crystal delay too short");
endmodule

bind config_word_decoder config_word_asserts #(
   .DRT_LONG_CYC(DRT_LONG_CYC)
) u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .nv_config_word(nv_config_word),
   .reset_pin_in(reset_pin_in),
   .core_reset_n(core_reset_n),
   .wdt_timeout(wdt_timeout),
   .osc_mode(osc_mode),
   .clkout_enable(clkout_enable),
   .osc2_is_port_b_bit_four(osc2_is_port_b_bit_four),
   .int_osc_8mhz(int_osc_8mhz),
   .reset_pin_is_gpio(reset_pin_is_gpio),
   .watchdog_enabled(watchdog_enabled),
   .program_protect_on(program_protect_on),
   .data_flash_protect_on(data_flash_protect_on)
);
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench for the configuration word decoder
module testbench
   import config_word_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0, nv = 0, cfg;
   logic [31:0] pwdata = 0, prdata, r, seed = 32'heb7e_2264;
   logic pready, pslverr, reset_pin_in = 1, wdt_osc_in = 0;
   logic wdt_clear = 0, core_reset_n, sleep_active, wdt_timeout;
   logic clkout_enable, port_b4, int_osc_8mhz, reset_pin_is_gpio;
   logic watchdog_enabled, prog_prot, data_prot;
   logic [5:0] wake_pin_in = 0;
   osc_mode_t osc_mode;
   logic [32:0] exp_q[$];
   int errors = 0, n_tests = 0, cyc = 0, n;

   // Shortened delays keep the run brief
   config_word_decoder #(.WDT_TICKS(4), .DRT_LONG_CYC(40),
      .DRT_SHORT_CYC(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nv_config_word(nv), .reset_pin_in(reset_pin_in),
      .wake_pin_in(wake_pin_in), .wdt_osc_in(wdt_osc_in),
      .wdt_clear(wdt_clear), .core_reset_n(core_reset_n),
      .sleep_active(sleep_active), .wdt_timeout(wdt_timeout),
      .osc_mode(osc_mode), .clkout_enable(clkout_enable),
      .osc2_is_port_b_bit_four(port_b4), .int_osc_8mhz(int_osc_8mhz),
      .reset_pin_is_gpio(reset_pin_is_gpio),
      .watchdog_enabled(watchdog_enabled),
      .program_protect_on(prog_prot),
      .data_flash_protect_on(data_prot));

   // ==========================================================
   // Clock, timeout and helpers
   initial
      forever #12.5 pclk = ~pclk;

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         errors++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask

   task automatic chk_port(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic chk_bus(input logic [32:0] ex);
      n_tests++;
      if ({pslverr, prdata} !== ex)
      begin
         errors++;
         $display("wrong value bus expected %h seen %h", ex,
            {pslverr, prdata});
      end
   endtask

   // Idle cycle first, so release and next setup never share a step
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] ex);
      exp_q.push_back(ex);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Oldest bus note against each answer
   always @(posedge pclk)
      if (pready === 1'b1 && exp_q.size() > 0)
         chk_bus(exp_q.pop_front());

   // Word only changes under power-up reset; n counts the hold
   task automatic boot(input logic [11:0] c);
      presetn <= 1'b0;
      nv <= c;
      tick(3);
      chk_port("held", 0, core_reset_n);
      presetn <= 1'b1;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 500)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic wdt_ticks(input int k);
      repeat (k)
      begin
         wdt_osc_in <= 1'b1;
         tick(3);
         wdt_osc_in <= 1'b0;
         tick(3);
      end
      tick(10);
   endtask

   // ==========================================================
   // Scenarios
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         r = xs();
         cfg = {r[11:3], i[2:0]};
         boot(cfg);
         chk_port("long_delay", i < 3, n >= 40);
         chk_port("mode", i, osc_mode);
         chk_port("clkout", i == 5 || i == 7, clkout_enable);
         chk_port("pin_b4", i inside {3, 4, 6}, port_b4);
         chk_port("speed", cfg[6], int_osc_8mhz);
         chk_port("wdt_en", cfg[3], watchdog_enabled);
         chk_port("rst_gpio", !cfg[5], reset_pin_is_gpio);
         chk_port("prot", {!cfg[7], !cfg[4]}, {data_prot, prog_prot});
         apb(1'b1, 12'h000, ~r, 33'h0_0000_0000);
         apb(1'b0, 12'h000, 0, {21'h0, cfg});
         apb(1'b0, 12'h0fc, 0, 33'h1_0000_0000);
      end
      // Reset pin enabled, then used as plain input
      boot(12'h02d);
      reset_pin_in <= 1'b0;
      tick(10);
      chk_port("pin_rst", 0, core_reset_n);
      reset_pin_in <= 1'b1;
      tick(20);
      chk_port("pin_rel", 1, core_reset_n);
      boot(12'h00d);
      reset_pin_in <= 1'b0;
      tick(10);
      chk_port("pin_gpio", 1, core_reset_n);
      reset_pin_in <= 1'b1;
      // Sleep with watchdog off then on
      for (int k = 0; k < 2; k++)
      begin
         boot(k ? 12'h02d : 12'h025);
         apb(1'b0, 12'h00c, 0, 33'h0_0000_0000);
         apb(1'b1, 12'h00c, 32'h1, 33'h0_0000_0000);
         apb(1'b0, 12'h00c, 0, 33'h0_0000_0001);
         apb(1'b1, 12'h008, 32'h1, 33'h0_0000_0000);
         tick(3);
         chk_port("sleep", 1, sleep_active);
         wdt_ticks(6);
         if (k == 0)
         begin
            chk_port("no_wdt_wake", 1, sleep_active);
            wake_pin_in[0] <= 1'b1;
            tick(10);
         end
         chk_port("woke", 0, sleep_active);
         apb(1'b0, 12'h004, 0, k ? 33'h28 : 33'h30);
      end
      // Time-out while running; flag from the wake is cleared first
      apb(1'b1, 12'h008, 32'h6, 33'h0_0000_0000);
      wdt_ticks(3);
      chk_port("wdt_clr", 0, wdt_timeout);
      wdt_clear <= 1'b1;
      tick(1);
      wdt_clear <= 1'b0;
      wdt_ticks(3);
      chk_port("wdt_core_clr", 0, wdt_timeout);
      wdt_ticks(1);
      chk_port("wdt_flag", 1, wdt_timeout);
      apb(1'b0, 12'h004, 0, 33'h0_0000_0028);
      tick(5);
      report_and_stop();
   end
endmodule
`default_nettype wire
